// ==== design/cdsp_pkg.sv ====
// shared constants and types for the codec serial port
package cdsp_pkg;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 5;
    localparam int SYNC_W = 4;
    localparam int BIT_TEN = 10;
    localparam int BIT_ELEVEN = 11;
    localparam int BYTE_GAP = 2;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic WB_BYTE = 1'b0;

    typedef enum {LK_IDLE, LK_LEAD, LK_PRI, LK_BGAP, LK_END, LK_SEC} cdsp_link_e;

    typedef struct packed {
        logic dual;
        logic byte_mode;
    } cdsp_mode_s;

    typedef struct packed {
        logic sec;
        logic [WORD_W-1:0] adc;
    } cdsp_req_s;

    typedef struct packed {
        logic [WORD_W-1:0] ctrl;
        logic [WORD_W-1:0] dac;
    } cdsp_rx_s;

    localparam cdsp_req_s REQ_RST = '0;
    localparam cdsp_rx_s RX_RST = '0;
endpackage

// ==== design/cdsp_sync.sv ====
// two-flop synchroniser, also used as a reset release synchroniser
`timescale 1ns/1ps
`default_nettype none
module cdsp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== design/cdsp_shreg.sv ====
// msb-first shift register with a registered serial output
`timescale 1ns/1ps
`default_nettype none
module cdsp_shreg (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic shift,
    input wire logic sin,
    input wire logic [cdsp_pkg::WORD_W-1:0] d,
    // alternate bit shown on the serial output
    input wire logic sel_alt,
    input wire logic alt,
    // results
    output logic [cdsp_pkg::WORD_W-1:0] q,
    output logic sout
);
    import cdsp_pkg::*;

    logic [WORD_W-1:0] q_next;

    always_comb begin
        q_next = q;
        if (load) begin
            q_next = d;
        end else if (shift) begin
            q_next = {q[WORD_W-2:0], sin};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= WORD_RST;
        end else begin
            q <= q_next;
        end
    end

    // output tracks the msb of the next contents so a bit appears with its edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sout <= 1'b0;
        end else begin
            sout <= sel_alt ? alt : q_next[WORD_W-1];
        end
    end
endmodule
`default_nettype wire

// ==== design/cdsp_port.sv ====
// serial port toward the dsp: frame syncs, shifting, strobes, mode pins
//
// What this block does
// - aux data input at a logic level selects dual-word mode; pin is data.
// - dual-word mode forwards aux data to serial output in secondary slot.
// - dual-word mode enables secondary sync and general outputs; else pins differ.
// - aux data input at negative supply selects word/byte mode.
// - word/byte mode enables width select input and both done strobes.
// - adc bits leave on serial data output in step with shift clock.
// - dac and control bits arrive on serial data input.
// - dual-word mode: general output a follows control bit ten at once.
// - reset clears control bit ten.
// - dual-word mode: general output b follows control bit eleven at once.
// - reset clears control bit eleven.
// - word timing: receive strobe pulses low after 16 bits shifted in.
// - byte timing: receive strobe low from first byte end to second byte end.
// - word timing: transmit strobe pulses low after 16 bits shifted out.
// - byte timing: transmit strobe low from first byte end to second byte end.
// - secondary frame sync stays low for 16 shift clock periods.
// - secondary frame sync stays high during primary communication.
// - adc msb is on serial output before adc frame sync falls.
// - aux data reaches serial output only while secondary sync is low.
`timescale 1ns/1ps
`default_nettype none
module cdsp_port (
    // system clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link clock
    input wire logic shift_clk,
    // sample request
    input wire logic [cdsp_pkg::WORD_W-1:0] adc_word,
    input wire logic sec_req,
    input wire logic adc_valid,
    output logic adc_ready,
    // received words
    output logic [cdsp_pkg::WORD_W-1:0] dac_word,
    output logic [cdsp_pkg::WORD_W-1:0] ctrl_word,
    output logic rx_valid,
    // mode pins
    input wire logic aux_at_neg_supply,
    input wire logic aux_data_in,
    input wire logic word_byte_in,
    // serial link
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic adc_frame_sync,
    output logic dac_frame_sync,
    output logic secondary_frame_sync,
    output logic secondary_frame_sync_oe,
    // general outputs and strobes
    output logic general_out_a,
    output logic general_out_b,
    output logic rx_done_strobe,
    output logic tx_done_strobe
);
    import cdsp_pkg::*;

    function automatic logic is_last(input logic [CNT_W-1:0] c, input logic bytes);
        logic [CNT_W-1:0] len;
        len = bytes ? CNT_W'(BYTE_W - 1) : CNT_W'(WORD_W - 1);
        return c == len;
    endfunction

    // ---------------- system side ----------------
    cdsp_req_s req_reg;
    logic start_tgl_reg;
    logic busy_reg;
    logic done_seen_reg;
    logic done_s;
    logic done_tgl_reg;
    cdsp_rx_s rx_hold_reg;

    cdsp_sync #(.W(1)) u_done_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(done_tgl_reg),
        .q(done_s)
    );

    wire logic take = adc_valid && adc_ready && !busy_reg;
    wire logic done_evt = done_s != done_seen_reg;

    // request word is held until the link hands back completion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_reg <= REQ_RST;
            start_tgl_reg <= 1'b0;
            busy_reg <= 1'b0;
            adc_ready <= 1'b0;
        end else begin
            if (take) begin
                req_reg <= {sec_req, adc_word};
                start_tgl_reg <= !start_tgl_reg;
                busy_reg <= 1'b1;
                adc_ready <= 1'b0;
            end else if (done_evt) begin
                busy_reg <= 1'b0;
                adc_ready <= 1'b1;
            end else begin
                adc_ready <= !busy_reg;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_seen_reg <= 1'b0;
            dac_word <= WORD_RST;
            ctrl_word <= WORD_RST;
            rx_valid <= 1'b0;
        end else begin
            done_seen_reg <= done_s;
            rx_valid <= done_evt;
            if (done_evt) begin
                dac_word <= rx_hold_reg.dac;
                ctrl_word <= rx_hold_reg.ctrl;
            end
        end
    end

    // ---------------- link side ----------------
    logic lrst_n;
    logic [SYNC_W-1:0] pins_s;
    logic start_s;
    logic aux_neg_s;
    logic wb_s;
    logic aux_s;

    cdsp_sync #(.W(1)) u_rst_sync (
        .clk(shift_clk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(lrst_n)
    );

    cdsp_sync #(.W(SYNC_W)) u_pin_sync (
        .clk(shift_clk),
        .rst_n(lrst_n),
        .d({start_tgl_reg, aux_at_neg_supply, word_byte_in, aux_data_in}),
        .q(pins_s)
    );

    assign {start_s, aux_neg_s, wb_s, aux_s} = pins_s;

    cdsp_link_e state_reg;
    cdsp_link_e state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic start_seen_reg;
    logic second_reg;
    logic second_next;
    cdsp_mode_s mode_reg;
    logic ctrl_ten_reg;
    logic ctrl_eleven_reg;
    logic [WORD_W-1:0] rx_q;
    logic [WORD_W-1:0] rx_full;
    logic new_req;
    logic live_dual;
    logic last;
    logic sec_done;

    assign live_dual = !aux_neg_s;
    assign new_req = start_s != start_seen_reg;
    assign last = is_last(cnt_reg, mode_reg.byte_mode);
    assign rx_full = {rx_q[WORD_W-2:0], serial_data_in};
    assign sec_done = state_reg == LK_SEC && last;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LK_IDLE: begin
                if (new_req) begin
                    state_next = LK_LEAD;
                end
            end
            LK_LEAD: begin
                state_next = LK_PRI;
            end
            LK_PRI: begin
                if (last) begin
                    if (mode_reg.byte_mode && !second_reg) begin
                        state_next = LK_BGAP;
                    end else if (mode_reg.byte_mode) begin
                        state_next = LK_IDLE;
                    end else if (mode_reg.dual && req_reg.sec) begin
                        state_next = LK_SEC;
                    end else if (mode_reg.dual) begin
                        state_next = LK_IDLE;
                    end else begin
                        state_next = LK_END;
                    end
                end
            end
            LK_BGAP: begin
                if (cnt_reg == CNT_W'(BYTE_GAP - 1)) begin
                    state_next = LK_PRI;
                end
            end
            LK_END: begin
                state_next = LK_IDLE;
            end
            LK_SEC: begin
                if (is_last(cnt_reg, 1'b0)) begin
                    state_next = LK_IDLE;
                end
            end
            default: begin
                state_next = LK_IDLE;
            end
        endcase
    end

    always_comb begin
        cnt_next = (state_next != state_reg) ? CNT_ZERO : cnt_reg + CNT_ONE;
        second_next = second_reg;
        if (state_reg == LK_PRI && state_next == LK_BGAP) begin
            second_next = 1'b1;
        end else if (state_next == LK_IDLE) begin
            second_next = 1'b0;
        end
    end

    always_ff @(posedge shift_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state_reg <= LK_IDLE;
            cnt_reg <= CNT_ZERO;
            second_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            second_reg <= second_next;
        end
    end

    // mode is frozen for the length of a frame so a pin change cannot split it
    always_ff @(posedge shift_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            mode_reg <= '0;
            start_seen_reg <= 1'b0;
        end else if (state_reg == LK_IDLE && new_req) begin
            mode_reg.dual <= live_dual;
            mode_reg.byte_mode <= !live_dual && wb_s == WB_BYTE;
            start_seen_reg <= start_s;
        end
    end

    // tx word loads while idle so its msb leads the frame sync
    cdsp_shreg u_tx (
        .clk(shift_clk),
        .rst_n(lrst_n),
        .load(state_reg == LK_IDLE && new_req),
        .shift(state_reg == LK_PRI),
        .sin(1'b0),
        .d(req_reg.adc),
        .sel_alt(state_next == LK_SEC),
        .alt(aux_s),
        .q(),
        .sout(serial_data_out)
    );

    cdsp_shreg u_rx (
        .clk(shift_clk),
        .rst_n(lrst_n),
        .load(1'b0),
        .shift(state_reg == LK_PRI || state_reg == LK_SEC),
        .sin(serial_data_in),
        .d(WORD_RST),
        .sel_alt(1'b0),
        .alt(1'b0),
        .q(rx_q),
        .sout()
    );

    // completion toggle; each held word stays stable until the next word for its slot is fully shifted in
    always_ff @(posedge shift_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            done_tgl_reg <= 1'b0;
            rx_hold_reg <= RX_RST;
        end else begin
            if (state_reg == LK_PRI && last && state_next != LK_BGAP) begin
                rx_hold_reg.dac <= rx_full;
            end
            if (sec_done) begin
                rx_hold_reg.ctrl <= rx_full;
            end
            if (state_reg != LK_IDLE && state_next == LK_IDLE) begin
                done_tgl_reg <= !done_tgl_reg;
            end
        end
    end

    // control bits land on the same edge as the last control bit
    always_ff @(posedge shift_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            ctrl_ten_reg <= 1'b0;
            ctrl_eleven_reg <= 1'b0;
            general_out_a <= 1'b0;
            general_out_b <= 1'b0;
        end else begin
            if (sec_done) begin
                ctrl_ten_reg <= rx_full[BIT_TEN];
                ctrl_eleven_reg <= rx_full[BIT_ELEVEN];
                general_out_a <= live_dual && rx_full[BIT_TEN];
                general_out_b <= live_dual && rx_full[BIT_ELEVEN];
            end else begin
                general_out_a <= live_dual && ctrl_ten_reg;
                general_out_b <= live_dual && ctrl_eleven_reg;
            end
        end
    end

    // frame syncs and strobes are registered from the next state
    always_ff @(posedge shift_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            adc_frame_sync <= 1'b1;
            dac_frame_sync <= 1'b1;
            secondary_frame_sync <= 1'b1;
            secondary_frame_sync_oe <= 1'b0;
            rx_done_strobe <= 1'b1;
            tx_done_strobe <= 1'b1;
        end else begin
            adc_frame_sync <= state_next != LK_PRI;
            dac_frame_sync <= !(state_next == LK_PRI || state_next == LK_SEC);
            secondary_frame_sync <= state_next != LK_SEC;
            secondary_frame_sync_oe <= live_dual;
            rx_done_strobe <= !(!mode_reg.dual
                && (state_next == LK_END || second_next));
            tx_done_strobe <= !(!mode_reg.dual
                && (state_next == LK_END || second_next));
        end
    end
endmodule
`default_nettype wire

// ==== tb/cdsp_port_props.sv ====
// concurrent checks on the codec serial port pins
`timescale 1ns/1ps
`default_nettype none
module cdsp_port_props (
    // clocks and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic shift_clk,
    // request side
    input wire logic adc_valid,
    input wire logic adc_ready,
    input wire logic rx_valid,
    // mode pins
    input wire logic aux_at_neg_supply,
    input wire logic word_byte_in,
    // link pins
    input wire logic serial_data_out,
    input wire logic adc_frame_sync,
    input wire logic dac_frame_sync,
    input wire logic secondary_frame_sync,
    input wire logic secondary_frame_sync_oe,
    input wire logic rx_done_strobe,
    input wire logic tx_done_strobe
);
    wire logic word_pins = aux_at_neg_supply && word_byte_in;
    wire logic byte_pins = aux_at_neg_supply && !word_byte_in;
    sequence s_low;
        !rx_done_strobe && !tx_done_strobe;
    endsequence
    sequence s_high;
        rx_done_strobe && tx_done_strobe;
    endsequence
    a_word_pulse: assert property (@(posedge shift_clk) disable iff (!rst_n)
        $rose(adc_frame_sync) && word_pins |-> s_low ##1 s_high)
        else $error("word strobe not one shift clock wide");
    a_byte_hold: assert property (@(posedge shift_clk) disable iff (!rst_n)
        $fell(tx_done_strobe) && byte_pins |->
        (s_low[*8] ##1 s_low[*2] ##1 s_high) and (##2 !adc_frame_sync))
        else $error("byte strobe not held over second byte");
    a_sec_len: assert property (@(posedge shift_clk) disable iff (!rst_n)
        $fell(secondary_frame_sync) |->
        (!secondary_frame_sync)[*8] ##1 (!secondary_frame_sync)[*8] ##1 secondary_frame_sync)
        else $error("secondary sync not 16 shift clocks");
    a_pri_no_sec: assert property (@(posedge shift_clk) disable iff (!rst_n)
        !adc_frame_sync |-> secondary_frame_sync)
        else $error("secondary sync low in primary slot");
    a_msb_early: assert property (@(posedge shift_clk) disable iff (!rst_n)
        $fell(adc_frame_sync) && !byte_pins |-> $stable(serial_data_out))
        else $error("first bit not ready before frame sync");
    a_sec_slot: assert property (@(posedge shift_clk) disable iff (!rst_n)
        !secondary_frame_sync |-> !dac_frame_sync && adc_frame_sync)
        else $error("secondary slot framing wrong");
    a_wb_no_sec: assert property (@(posedge shift_clk) disable iff (!rst_n)
        aux_at_neg_supply && $past(aux_at_neg_supply, 12) |->
        !secondary_frame_sync_oe && secondary_frame_sync)
        else $error("secondary sync active in word/byte mode");
    a_dual_quiet: assert property (@(posedge shift_clk) disable iff (!rst_n)
        !aux_at_neg_supply |-> s_high)
        else $error("done strobe in dual-word mode");
    a_ready_drop: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && adc_ready |=> !adc_ready)
        else $error("ready stayed high after take");
    a_rx_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rx_valid) |-> adc_ready ##1 !rx_valid)
        else $error("rx_valid not a single pulse");
endmodule
bind cdsp_port cdsp_port_props u_props (
    .clk(clk), .rst_n(rst_n), .shift_clk(shift_clk), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .rx_valid(rx_valid), .aux_at_neg_supply(aux_at_neg_supply),
    .word_byte_in(word_byte_in), .serial_data_out(serial_data_out),
    .adc_frame_sync(adc_frame_sync), .dac_frame_sync(dac_frame_sync),
    .secondary_frame_sync(secondary_frame_sync),
    .secondary_frame_sync_oe(secondary_frame_sync_oe),
    .rx_done_strobe(rx_done_strobe), .tx_done_strobe(tx_done_strobe)
);
`default_nettype wire

// ==== tb/cdsp_dsp_model.sv ====
// behavioural dsp serial port facing the codec
`timescale 1ns/1ps
`default_nettype none
module cdsp_dsp_model (
    // link
    input wire logic shift_clk,
    input wire logic serial_data_out,
    input wire logic adc_frame_sync,
    input wire logic dac_frame_sync,
    input wire logic secondary_frame_sync,
    output logic serial_data_in,
    // bench side
    input wire logic load,
    input wire logic [31:0] tx_bits,
    output logic [15:0] cap_pri,
    output logic [15:0] cap_sec
);
    logic [31:0] tx_reg = 32'h0;
    // change on falling edges so the codec samples settled bits
    always @(negedge shift_clk) begin
        if (load) begin
            tx_reg <= tx_bits;
        end else if (!dac_frame_sync) begin
            serial_data_in <= tx_reg[31];
            tx_reg <= {tx_reg[30:0], 1'b0};
        end else begin
            // released line toggles so a held bit is never mistaken for data
            serial_data_in <= (serial_data_in === 1'b1) ? 1'b0 : 1'b1;
        end
        if (!adc_frame_sync) cap_pri <= {cap_pri[14:0], serial_data_out};
        if (!secondary_frame_sync) cap_sec <= {cap_sec[14:0], serial_data_out};
    end
endmodule
`default_nettype wire

// ==== tb/cdsp_port_bench.sv ====
// self-checking bench for the codec serial port
`timescale 1ns/1ps
`default_nettype none
module cdsp_port_bench;
    import cdsp_pkg::*;
    logic clk = 1'b0;
    logic shift_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [WORD_W-1:0] adc_word = '0;
    logic sec_req = 1'b0;
    logic adc_valid = 1'b0;
    logic aux_at_neg_supply = 1'b1;
    logic aux_data_in = 1'b0;
    logic word_byte_in = 1'b1;
    logic load = 1'b0;
    logic [31:0] tx_bits = '0;
    logic [WORD_W-1:0] last_ctl = '0;
    wire logic adc_ready, rx_valid, serial_data_in, serial_data_out, sec_oe;
    wire logic adc_fs, dac_fs, sec_fs, out_a, out_b, rx_strobe, tx_strobe;
    wire logic [WORD_W-1:0] dac_word, ctrl_word;
    wire logic [15:0] cap_pri, cap_sec;
    int n_fail = 0;
    int tests_run = 0;
    logic timed_out = 1'b0;

    always #20 clk = ~clk;
    // odd offset keeps link edges clear of system clock edges
    initial #3.7 forever #7.5 shift_clk = ~shift_clk;

    cdsp_port u_dut (.clk(clk), .rst_n(rst_n), .shift_clk(shift_clk), .adc_word(adc_word),
        .sec_req(sec_req), .adc_valid(adc_valid), .adc_ready(adc_ready),
        .dac_word(dac_word), .ctrl_word(ctrl_word), .rx_valid(rx_valid),
        .aux_at_neg_supply(aux_at_neg_supply), .aux_data_in(aux_data_in),
        .word_byte_in(word_byte_in), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .adc_frame_sync(adc_fs),
        .dac_frame_sync(dac_fs), .secondary_frame_sync(sec_fs),
        .secondary_frame_sync_oe(sec_oe), .general_out_a(out_a), .general_out_b(out_b),
        .rx_done_strobe(rx_strobe), .tx_done_strobe(tx_strobe));
    cdsp_dsp_model u_dsp (.shift_clk(shift_clk), .serial_data_out(serial_data_out),
        .adc_frame_sync(adc_fs), .dac_frame_sync(dac_fs), .secondary_frame_sync(sec_fs),
        .serial_data_in(serial_data_in), .load(load), .tx_bits(tx_bits),
        .cap_pri(cap_pri), .cap_sec(cap_sec));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [1:0] exp_outs(input int md);
        return (md >= 2) ? {last_ctl[BIT_ELEVEN], last_ctl[BIT_TEN]} : 2'b00;
    endfunction

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        last_ctl = '0;
    endtask

    // md: 0 word, 1 byte, 2 dual with secondary, 3 dual primary only
    task automatic run_frame(input int md, input logic [15:0] adc, input logic [15:0] dac,
                             input logic [15:0] ctl, input logic aux);
        int k;
        if (timed_out) return;
        aux_at_neg_supply = (md < 2);
        word_byte_in = (md == 0);
        sec_req = (md == 2);
        aux_data_in = aux;
        adc_word = adc;
        tx_bits = {dac, ctl};
        load = 1'b1;
        // mode pins need a few cycles through the synchronisers
        repeat (4) @(posedge clk);
        #1 load = 1'b0;
        check(sec_oe, md >= 2);
        k = 0;
        while (adc_ready !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1 k++;
        end
        adc_valid = 1'b1;
        @(posedge clk);
        #1 adc_valid = 1'b0;
        while (rx_valid !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1 k++;
        end
        if (k >= 300) begin
            n_fail++;
            timed_out = 1'b1;
            return;
        end
        if (md == 2) last_ctl = ctl;
        check(dac_word, dac);
        check(cap_pri, adc);
        if (md == 2) check(ctrl_word, ctl);
        if (md == 2) check(cap_sec, {16{aux}});
        check({out_b, out_a}, exp_outs(md));
    endtask

    initial begin
        void'($urandom(32'h51CB));
        do_reset();
        run_frame(3, 16'h8001, 16'h7FFE, 16'hFFFF, 1'b1);
        run_frame(2, 16'hFFFF, 16'h0000, 16'h0C00, 1'b0);
        run_frame(2, 16'h0001, 16'hA5A5, 16'hF3FF, 1'b1);
        run_frame(0, 16'h8000, 16'hFFFF, 16'h0000, 1'b0);
        run_frame(1, 16'h00FF, 16'hFF00, 16'h0000, 1'b1);
        for (int i = 0; i < 24; i++) begin
            if (i == 12) do_reset();
            run_frame($urandom_range(3), 16'($urandom), 16'($urandom), 16'($urandom),
                      1'($urandom));
        end
        print_verdict();
    end
endmodule
`default_nettype wire
